/* rtl/flux_lock_defs.vh */
`ifndef FLUX_LOCK_DEFS_VH
`define FLUX_LOCK_DEFS_VH

// ********************************************************
// Register map
// ********************************************************
`define FLUX_CTRL_ADDR    12'h04C
`define LOCK_CFG_ADDR     12'h050
`define IRQ_STATUS_ADDR   12'h058
`define IRQ_MASK_ADDR     12'h05C
`define LOCK_STATUS_ADDR  12'h060
`define LOCK_CLEAR_ADDR   12'h064

`define FLUX_CTRL_RESET   32'h0000_0000
`define LOCK_CFG_RESET    32'h0000_0000
`define FLUX_CTRL_MASK    32'h0000_007F

// ********************************************************
// Field positions
// ********************************************************
`define TPA_EN_BIT        6
`define MI_TARGET_MSB     5
`define MI_TARGET_LSB     4
`define FW_CAP_MSB        3
`define FW_CAP_LSB        1
`define FW_EN_BIT         0
`define RETRY_MSB         5
`define RETRY_LSB         2
`define MODE_MSB          1
`define MODE_LSB          0

// ********************************************************
// Stall response modes
// ********************************************************
`define MODE_LATCHED      2'h0
`define MODE_AUTO_RETRY   2'h1
`define MODE_REPORT_ONLY  2'h2
`define MODE_DISABLED     2'h3

// ********************************************************
// Interrupt status bits
// ********************************************************
`define IRQ_LOCK_BIT      0
`define IRQ_RELEASE_BIT   1
`define IRQ_WIDTH         2

// ********************************************************
// Retry times in milliseconds, clock period in nanoseconds and ns per ms
// ********************************************************
`define RETRY_CODE0_MS    100
`define RETRY_CODE1_MS    500
`define RETRY_CODE2_MS    1000
`define RETRY_STEP_MS     1000
`define RETRY_BASE_MS     2000
`define CLK_PERIOD_NS     10
`define NS_PER_MS         1000000

`endif

/* rtl/flux_and_lock_fault_config.v */
`timescale 1ns/1ps
`include "flux_lock_defs.vh"

// Overview of operation
// - Flux control at 0x4C resets to zero; bits 31..7 read zero.
// - Bit 6 enables max torque per amp control.
// - Bits 5..4 pick modulation index target 70/80/90/95 percent.
// - Bits 3..1 cap weakening current: 0 circular, 1..7 80..20 percent.
// - Bit 0 enables flux weakening control.
// - Lock fault settings at 0x50 reset zero; bits 31..6 plain storage.
// - Bits 5..2 pick retry time 100ms, 500ms, 1s, then 2s..14s.
// - Mode 0: stall latches fault and drives fault output low.
// - Mode 1: stall fault self-clears after the retry time.
// - Mode 2: stall reported in status, on stall_reported and on the lock interrupt, drive untouched.
// - Mode 3: stall detection ignored entirely.
module flux_and_lock_fault_config #(
	parameter MS_CYCLES = `NS_PER_MS / `CLK_PERIOD_NS
) (
	// Clock, reset, enable
	input  wire        pclk,
	input  wire        presetn,
	input  wire        clk_en,
	// APB slave
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [11:0] paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output reg         pready,
	output reg         pslverr,
	// Stall detector from the control loop
	input  wire        stall_detect,
	// Settings toward the control loop
	output reg         torque_per_amp_enable,
	output reg  [1:0]  mi_target_sel,
	output reg  [2:0]  field_weakening_current_cap,
	output reg         flux_weak_enable,
	// Fault reporting
	output reg         fault_output_n,
	output reg         drive_disable,
	output reg         stall_reported,
	output reg         irq
);

	// ********************************************************
	// Registers
	// ********************************************************
	reg  [31:0]           flux_reg;
	reg  [31:0]           lock_cfg_reg;
	reg  [`IRQ_WIDTH-1:0] irq_status_reg;
	reg  [`IRQ_WIDTH-1:0] irq_mask_reg;
	reg                   fault_active_reg;
	reg                   report_reg;
	// Wide enough for a full millisecond at the real clock rate
	reg  [31:0]           ms_count_reg;
	reg  [13:0]           retry_ms_reg;
	reg                   stall_meta_reg;
	reg                   stall_sync_reg;

	wire        wr_en;
	wire        rd_en;
	wire [1:0]  mode;
	wire [3:0]  retry_code;
	wire        sw_clear;
	wire        report_clear;
	localparam [31:0] MS_LAST = MS_CYCLES - 1;
	reg  [13:0] retry_target_ms;
	reg         addr_ok;
	reg  [31:0] rd_mux;

	assign wr_en = psel & penable & pwrite & clk_en;
	assign rd_en = psel & ~penable & ~pwrite;
	assign mode = lock_cfg_reg[`MODE_MSB:`MODE_LSB];
	assign retry_code = lock_cfg_reg[`RETRY_MSB:`RETRY_LSB];
	assign sw_clear = wr_en & (paddr == `LOCK_CLEAR_ADDR) & pwdata[0];
	// Report flag clear is its own bit, independent of the fault clear
	assign report_clear = wr_en & (paddr == `LOCK_CLEAR_ADDR) & pwdata[1];

	// ********************************************************
	// Retry time decode
	// ********************************************************
	always @* begin
		case (retry_code)
		4'h0: retry_target_ms = 14'd`RETRY_CODE0_MS;
		4'h1: retry_target_ms = 14'd`RETRY_CODE1_MS;
		4'h2: retry_target_ms = 14'd`RETRY_CODE2_MS;
		default: retry_target_ms = 14'd`RETRY_BASE_MS
			+ ({10'h000, retry_code} - 14'd3) * 14'd`RETRY_STEP_MS;
		endcase
	end

	// ********************************************************
	// Address decode and read mux
	// ********************************************************
	always @* begin
		addr_ok = 1'b1;
		rd_mux = 32'h0000_0000;
		case (paddr)
		`FLUX_CTRL_ADDR: rd_mux = flux_reg & `FLUX_CTRL_MASK;
		`LOCK_CFG_ADDR: rd_mux = lock_cfg_reg;
		`IRQ_STATUS_ADDR: rd_mux = {30'h0, irq_status_reg};
		`IRQ_MASK_ADDR: rd_mux = {30'h0, irq_mask_reg};
		`LOCK_STATUS_ADDR: rd_mux = {30'h0, report_reg, fault_active_reg};
		`LOCK_CLEAR_ADDR: rd_mux = 32'h0000_0000;
		default: addr_ok = 1'b0;
		endcase
	end

	// ********************************************************
	// APB handshake: answer in the cycle after setup
	// ********************************************************
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else if (clk_en) begin
			pready <= psel & ~penable;
			pslverr <= psel & ~penable & ~addr_ok;
			if (rd_en)
				prdata <= rd_mux;
		end
	end

	// ********************************************************
	// Configuration registers
	// ********************************************************
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flux_reg <= `FLUX_CTRL_RESET;
			lock_cfg_reg <= `LOCK_CFG_RESET;
			irq_mask_reg <= {`IRQ_WIDTH{1'b0}};
		end else if (wr_en) begin
			if (paddr == `FLUX_CTRL_ADDR)
				flux_reg <= pwdata & `FLUX_CTRL_MASK;
			if (paddr == `LOCK_CFG_ADDR)
				lock_cfg_reg <= pwdata;
			if (paddr == `IRQ_MASK_ADDR)
				irq_mask_reg <= pwdata[`IRQ_WIDTH-1:0];
		end
	end

	// ********************************************************
	// Settings outputs
	// ********************************************************
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			torque_per_amp_enable <= 1'b0;
			mi_target_sel <= 2'h0;
			field_weakening_current_cap <= 3'h0;
			flux_weak_enable <= 1'b0;
		end else if (clk_en) begin
			torque_per_amp_enable <= flux_reg[`TPA_EN_BIT];
			mi_target_sel <= flux_reg[`MI_TARGET_MSB:`MI_TARGET_LSB];
			field_weakening_current_cap <=
				flux_reg[`FW_CAP_MSB:`FW_CAP_LSB];
			flux_weak_enable <= flux_reg[`FW_EN_BIT];
		end
	end

	// ********************************************************
	// Stall input synchroniser
	// ********************************************************
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stall_meta_reg <= 1'b0;
			stall_sync_reg <= 1'b0;
		end else if (clk_en) begin
			stall_meta_reg <= stall_detect;
			stall_sync_reg <= stall_meta_reg;
		end
	end

	// ********************************************************
	// Stall fault handling
	// ********************************************************
	wire stall_seen;
	wire retry_done;
	wire fault_set;
	wire fault_release;
	wire report_set;
	assign stall_seen = stall_sync_reg & (mode != `MODE_DISABLED);
	assign fault_set = stall_seen & ~fault_active_reg
		& ((mode == `MODE_LATCHED) | (mode == `MODE_AUTO_RETRY));
	assign report_set = stall_seen & (mode == `MODE_REPORT_ONLY);
	assign retry_done = (retry_ms_reg >= retry_target_ms)
		& (ms_count_reg == 32'h0000_0000);
	// Auto retry releases only once the timer expires
	assign fault_release = fault_active_reg & ((mode == `MODE_AUTO_RETRY)
		? retry_done : sw_clear);

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fault_active_reg <= 1'b0;
			report_reg <= 1'b0;
			ms_count_reg <= 32'h0000_0000;
			retry_ms_reg <= 14'd0;
		end else if (clk_en) begin
			if (fault_set) begin
				fault_active_reg <= 1'b1;
				ms_count_reg <= 32'h0000_0000;
				retry_ms_reg <= 14'd0;
			end else if (fault_release) begin
				fault_active_reg <= 1'b0;
			end else if (fault_active_reg) begin
				if (ms_count_reg == MS_LAST) begin
					ms_count_reg <= 32'h0000_0000;
					retry_ms_reg <= retry_ms_reg + 14'd1;
				end else begin
					ms_count_reg <= ms_count_reg + 32'h0000_0001;
				end
			end
			// Report flag: set wins over software clear
			if (report_set)
				report_reg <= 1'b1;
			else if (report_clear)
				report_reg <= 1'b0;
		end
	end

	// ********************************************************
	// Interrupts: write one to clear, set wins
	// ********************************************************
	wire [`IRQ_WIDTH-1:0] irq_events;
	wire [`IRQ_WIDTH-1:0] irq_clear;
	assign irq_events = {fault_release, fault_set | report_set};
	assign irq_clear = (wr_en && paddr == `IRQ_STATUS_ADDR)
		? pwdata[`IRQ_WIDTH-1:0] : {`IRQ_WIDTH{1'b0}};

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_status_reg <= {`IRQ_WIDTH{1'b0}};
			irq <= 1'b0;
			fault_output_n <= 1'b1;
			drive_disable <= 1'b0;
			stall_reported <= 1'b0;
		end else if (clk_en) begin
			irq_status_reg <= (irq_status_reg & ~irq_clear) | irq_events;
			irq <= |(irq_status_reg & irq_mask_reg);
			// Mode 2 reaches only stall_reported and the lock interrupt status bit, never the fault or drive outputs
			fault_output_n <= ~fault_active_reg;
			drive_disable <= fault_active_reg;
			stall_reported <= report_reg | fault_active_reg;
		end
	end

endmodule

/* verification/flux_lock_partner.sv */
`timescale 1ns/1ps
module stall_source #(
	parameter HOLD = 3
) (
	input  wire pclk,
	input  wire go,
	output wire stall_detect
);
	int n = 0;
	// Rotor held still for HOLD cycles per request, then free again
	always @(posedge pclk) begin
		if (go)
			n <= HOLD;
		else if (n > 0)
			n <= n - 1;
	end
	assign stall_detect = (n > 0);
endmodule

/* verification/flux_lock_chk.sv */
`timescale 1ns/1ps
module flux_lock_chk #(
	parameter MS_CYCLES = 10
) (
	input wire        pclk,
	input wire        presetn,
	input wire        psel,
	input wire        penable,
	input wire        pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	input wire [31:0] prdata,
	input wire        pready,
	input wire        pslverr,
	input wire        stall_detect,
	input wire        torque_per_amp_enable,
	input wire [1:0]  mi_target_sel,
	input wire [2:0]  field_weakening_current_cap,
	input wire        flux_weak_enable,
	input wire        fault_output_n,
	input wire        drive_disable,
	input wire        stall_reported
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// **********
	// Relations
	// **********
	sequence setup_s;
		psel && !penable;
	endsequence
	sequence acc_s;
		psel && penable && pready && paddr == 12'h04C;
	endsequence
	AST_SETUP_ACK: assert property (setup_s |=> pready)
		else $error("no ready after setup");
	AST_READY_ONE: assert property (pready |=> !pready)
		else $error("ready too long");
	AST_ERR_READY: assert property (pslverr |-> pready)
		else $error("error without ready");
	AST_FLUX_RD: assert property (
		acc_s and !pwrite |-> prdata[31:7] == 25'h000_0000)
		else $error("reserved flux bits set");
	AST_FLUX_WR: assert property (
		acc_s and pwrite |=> ##1 {torque_per_amp_enable, mi_target_sel,
		field_weakening_current_cap, flux_weak_enable} ==
		$past(pwdata[6:0], 2)) else $error("flux outputs wrong");
	AST_FAULT_DRIVE: assert property (fault_output_n != drive_disable)
		else $error("fault and drive disagree");
	AST_FAULT_FLAG: assert property (!fault_output_n |-> stall_reported)
		else $error("fault not reported");
	AST_FALL_CAUSE: assert property ($fell(fault_output_n) |->
		$past(stall_detect, 3) || $past(stall_detect, 4) ||
		$past(stall_detect, 5)) else $error("fault without stall");
endmodule

bind flux_and_lock_fault_config flux_lock_chk #(.MS_CYCLES(MS_CYCLES))
	i_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
	.prdata, .pready, .pslverr, .stall_detect, .torque_per_amp_enable,
	.mi_target_sel, .field_weakening_current_cap, .flux_weak_enable,
	.fault_output_n, .drive_disable, .stall_reported);

/* verification/flux_and_lock_fault_config_test.sv */
`timescale 1ns/1ps
`include "flux_lock_defs.vh"
module flux_and_lock_fault_config_test;
	logic        pclk, presetn, psel, penable, pwrite, go, stall_detect, err;
	logic        pready, pslverr, torque_per_amp_enable, flux_weak_enable;
	logic        fault_output_n, drive_disable, stall_reported, irq;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, d;
	logic [1:0]  mi_target_sel;
	logic [2:0]  field_weakening_current_cap;
	int          fails, tests_run, cyc;

	flux_and_lock_fault_config #(.MS_CYCLES(10)) i_dut (.pclk, .presetn,
		.clk_en(1'b1), .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .stall_detect, .torque_per_amp_enable,
		.mi_target_sel, .field_weakening_current_cap, .flux_weak_enable,
		.fault_output_n, .drive_disable, .stall_reported, .irq);
	stall_source i_stall (.pclk, .go, .stall_detect);

	initial begin
		pclk = 0;
		forever #5 pclk = ~pclk;
	end
	// Hang guard, well above the 100 ms retry wait that the test runs
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 20000) begin
			fails++;
			final_report;
		end
	end
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		tests_run++;
		if (g !== e) begin
			fails++;
			$display("mismatch t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] wd);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		d = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic stall(input int wait_cyc);
		go <= 1'b1;
		@(posedge pclk);
		go <= 1'b0;
		repeat (wait_cyc) @(posedge pclk);
	endtask
	task automatic final_report;
		$display("fails=%0d tests_run=%0d", fails, tests_run);
		if (fails == 0 && tests_run > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	initial begin
		presetn = 0;
		{psel, penable, pwrite, go} = 4'h0;
		paddr = 12'h000;
		pwdata = 32'h0000_0000;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		apb(0, `FLUX_CTRL_ADDR, 0);
		chk(d, 32'h0000_0000);
		apb(0, `LOCK_CFG_ADDR, 0);
		chk(d, 32'h0000_0000);
		apb(1, `FLUX_CTRL_ADDR, 32'hFFFF_FFFF);
		apb(0, `FLUX_CTRL_ADDR, 0);
		chk(d, 32'h0000_007F);
		apb(1, `FLUX_CTRL_ADDR, 32'h0000_0035);
		repeat (2) @(posedge pclk);
		chk({torque_per_amp_enable, mi_target_sel,
			field_weakening_current_cap, flux_weak_enable}, 7'h35);
		apb(1, `LOCK_CFG_ADDR, 32'hFFFF_FFFF);
		apb(0, `LOCK_CFG_ADDR, 0);
		chk(d, 32'hFFFF_FFFF);
		apb(0, 12'h040, 0);
		chk(d, 32'h0000_0000);
		chk({31'h0, err}, 32'h0000_0001);
		// Latched: must outlive the stall itself
		apb(1, `IRQ_MASK_ADDR, 1);
		apb(1, `LOCK_CFG_ADDR, 0);
		stall(30);
		chk({fault_output_n, drive_disable, irq}, 3'h3);
		apb(1, `IRQ_STATUS_ADDR, 1);
		repeat (3) @(posedge pclk);
		chk({fault_output_n, irq}, 2'h0);
		apb(1, `LOCK_CLEAR_ADDR, 1);
		repeat (3) @(posedge pclk);
		chk({fault_output_n, drive_disable}, 2'h2);
		// Auto retry, shortest code: 100 ms of 10 cycles each
		apb(1, `LOCK_CFG_ADDR, 1);
		stall(900);
		chk(fault_output_n, 1'h0);
		repeat (200) @(posedge pclk);
		chk(fault_output_n, 1'h1);
		apb(1, `LOCK_CFG_ADDR, 2);
		stall(10);
		chk({fault_output_n, drive_disable, stall_reported}, 3'h5);
		apb(1, `LOCK_CLEAR_ADDR, 2);
		apb(1, `LOCK_CFG_ADDR, 3);
		stall(10);
		chk({fault_output_n, drive_disable, stall_reported}, 3'h4);
		final_report;
	end
endmodule
